/* File: hdl/dlt_pkg.sv */
// Constants and types shared by the link training sequencer and its helpers.
// Assumes one receiving die with a fixed number of lane groups.
`default_nettype none
package dlt_pkg;
  // Lane groups in this link instance and lanes per group.
  localparam int NUM_GROUPS = 2;
  localparam int LANES      = 42;
  localparam int PAT_W      = 40;
  localparam int CNT_W      = 24;
  // Pattern generator preset and Galois feedback mask.
  localparam logic [PAT_W-1:0] PAT_SEED = 40'hAA_AAAA_AAAA;
  localparam logic [PAT_W-1:0] PAT_TAPS = 40'h80_0028_0001;
  // Pin sync width: lock, two per group, phase one and two done.
  localparam int PIN_W = 3 + 2 * NUM_GROUPS;

  // Link sequence, Gray coded along the usual path.
  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_LOCK    = 4'b0001,
    S_GROUPS  = 4'b0011,
    S_HS_WAIT = 4'b0010,
    S_P1      = 4'b0110,
    S_P1_END  = 4'b0111,
    S_P2      = 4'b0101,
    S_P2_END  = 4'b0100,
    S_MISSION = 4'b1100
  } seq_st_t;

  // Per lane group steps, Gray coded.
  typedef enum logic [1:0] {
    G_IDLE = 2'b00,
    G_CAL  = 2'b01,
    G_LSR  = 2'b11,
    G_DONE = 2'b10
  } grp_st_t;
endpackage
`default_nettype wire

/* File: hdl/bit_sync.sv */
// Two flip-flop synchroniser for levels and toggles.
// Assumes each bit is independent; words must not pass through here.
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t c_q;
  sync_state_t c_d;

  // The first stage feeds only the second stage.
  always_comb begin
    c_d      = c_q;
    c_d.meta = d;
    c_d.sync = c_q.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign q = c_q.sync;
endmodule
`default_nettype wire

/* File: hdl/lane_pattern_compare.sv */
// Receive side pattern run on the link clock: presets a Galois generator,
// compares each received word and gathers per-lane sticky errors.
// Assumes the far transmitter starts its seeded pattern with the run.
`default_nettype none
module lane_pattern_compare (
  input  wire logic                      link_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      run_tgl,
  input  wire logic [dlt_pkg::CNT_W-1:0] pat_count,
  input  wire logic [dlt_pkg::PAT_W-1:0] lane_data,
  output var  logic                      done_tgl,
  output var  logic [dlt_pkg::PAT_W-1:0] sticky
);
  typedef struct packed {
    logic                      run_seen;
    logic                      active;
    logic                      primed;
    logic [dlt_pkg::CNT_W-1:0] cnt;
    logic [dlt_pkg::PAT_W-1:0] lfsr;
    logic [dlt_pkg::PAT_W-1:0] data;
    logic [dlt_pkg::PAT_W-1:0] sticky;
    logic                      done_tgl;
  } cmp_state_t;

  cmp_state_t c_q;
  cmp_state_t c_d;
  logic       run_s;

  bit_sync #(.W(1)) u_run_sync (
    .clk (link_clk),
    .rst (sys_rst),
    .d   (run_tgl),
    .q   (run_s)
  );

  // One Galois step; the count alone sets run length, so any line rate
  // works without software pacing.
  function automatic logic [dlt_pkg::PAT_W-1:0] galois_step(
    input logic [dlt_pkg::PAT_W-1:0] s);
    galois_step = s[0] ? ((s >> 1) ^ dlt_pkg::PAT_TAPS) : (s >> 1);
  endfunction

  // Compare is a plain bitwise check against the local generator, so it
  // needs no transition density or balance on the lanes.
  always_comb begin
    c_d          = c_q;
    c_d.data     = lane_data;
    c_d.run_seen = run_s;
    if (run_s != c_q.run_seen) begin
      c_d.active = 1'b1;
      c_d.primed = 1'b0;
      c_d.lfsr   = dlt_pkg::PAT_SEED;
      c_d.sticky = '0;
      c_d.cnt    = (pat_count == '0) ? 24'h00_0001 : pat_count;
    end else if (c_q.active) begin
      c_d.primed = 1'b1;
      if (c_q.primed) begin
        c_d.sticky = c_q.sticky | (c_q.data ^ c_q.lfsr);
        c_d.lfsr   = galois_step(c_q.lfsr);
        c_d.cnt    = c_q.cnt - 24'h00_0001;
        if (c_q.cnt == 24'h00_0001) begin
          c_d.active   = 1'b0;
          c_d.done_tgl = ~c_q.done_tgl;
        end
      end
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // Sticky bits stay still from the done toggle until the next run.
  assign done_tgl = c_q.done_tgl;
  assign sticky   = c_q.sticky;
endmodule
`default_nettype wire

/* File: hdl/die_link_training_sequencer.sv */
// Receive-die training sequencer for a die-to-die parallel link.
// Assumes control bits come from serial configuration logic on ref_clk
// and analog step-done flags arrive as asynchronous levels.
// Only toggles are synchronised between the clocks; the count and sticky word cross held still.
// Pin flags must stay high until used.
//
// Operation
// - Clock lock is awaited once for the link before any group step.
// - Per group, driver calibration then low-speed repair, both before HS.
// - Phase one: pattern detect, clock position, reference level, deskew.
// - Receiver flags end of phase one to the transmitter.
// - Phase two uses the pseudo-random pattern to centre sampling.
// - End of phase two is flagged with marginal-lane data if tested.
// - Both ends enter normal operation together after final repair.
// - Broken-lane detection uses the pattern generator and compare.
// - Broken-lane detection works at any supported data rate.
// - Training is started and controlled over the configuration port.
// - No traffic pause for retraining once normal operation begins.
// - Detection may run before low-speed repair and during phase one.
// - Timing tracking does not rely on data transition density.
// - Failure sets error and sticky bits; completion sets done bit.
// - Pattern generators are preset to the defined seed before runs.
`default_nettype none
module die_link_training_sequencer (
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           link_clk,
  input  wire logic [dlt_pkg::PAT_W-1:0]      lane_data,
  input  wire logic                           pll_lock,
  input  wire logic [dlt_pkg::NUM_GROUPS-1:0] drv_cal_done,
  input  wire logic [dlt_pkg::NUM_GROUPS-1:0] ls_repair_done,
  input  wire logic                           p1_train_done,
  input  wire logic                           p2_train_done,
  input  wire logic                           train_start,
  input  wire logic                           bld_enable,
  input  wire logic                           hs_mode_set,
  input  wire logic                           p1_end_ack,
  input  wire logic                           p2_start,
  input  wire logic                           p2_end_ack,
  input  wire logic                           margin_valid,
  input  wire logic [dlt_pkg::LANES-1:0]      margin_lanes,
  input  wire logic                           mission_enter,
  input  wire logic [dlt_pkg::CNT_W-1:0]      pattern_count,
  output var  logic [3:0]                     seq_state,
  output var  logic [dlt_pkg::NUM_GROUPS-1:0] group_done,
  output var  logic                           rx_hs_mode,
  output var  logic                           pattern_active,
  output var  logic                           p1_end,
  output var  logic                           p2_end,
  output var  logic                           marginal_valid,
  output var  logic [dlt_pkg::LANES-1:0]      marginal_lanes,
  output var  logic [dlt_pkg::PAT_W-1:0]      compare_sticky,
  output var  logic [1:0]                     rx_training_status_reg,
  output var  logic                           mission_mode
);
  // Group count for loops and widths.
  localparam int G = dlt_pkg::NUM_GROUPS;

  // All state in one register.
  typedef struct packed {
    dlt_pkg::seq_st_t              st;
    dlt_pkg::grp_st_t [G-1:0]      grp;
    logic                          run_tgl;
    logic                          busy;
    logic                          done_seen;
    logic [dlt_pkg::PAT_W-1:0]     sticky;
    logic                          p1_end;
    logic                          p2_end;
    logic                          train_err;
    logic                          init_done;
    logic                          hs_mode;
    logic                          mission;
    logic                          marg_valid;
    logic [dlt_pkg::LANES-1:0]     marginal;
    logic [G-1:0]                  grp_done;
  } seq_state_t;

  // State and synchronised pin views.
  seq_state_t                c_q;
  seq_state_t                c_d;
  logic [dlt_pkg::PIN_W-1:0] pins_s;
  logic                      lock_s;
  logic [G-1:0]              cal_s;
  logic [G-1:0]              lsr_s;
  logic                      p1_s;
  logic                      p2_s;
  // Link results, used after the toggle.
  logic                      done_tgl_l;
  logic                      done_s;
  logic [dlt_pkg::PAT_W-1:0] sticky_l;

  // Analog step flags are asynchronous; they are synchronised together.
  // Each bit is an independent level.
  bit_sync #(.W(dlt_pkg::PIN_W)) u_pin_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({pll_lock, drv_cal_done, ls_repair_done,
           p1_train_done, p2_train_done}),
    .q   (pins_s)
  );

  // Bit order follows the sync input.
  assign lock_s = pins_s[dlt_pkg::PIN_W-1];
  assign cal_s  = pins_s[2*G+1:G+2];
  assign lsr_s  = pins_s[G+1:2];
  assign p1_s   = pins_s[1];
  assign p2_s   = pins_s[0];

  // The pattern run lives on the link clock; the run request and the
  // completion each cross as a toggle.
  // The count is held during a run.
  lane_pattern_compare u_compare (
    .link_clk  (link_clk),
    .sys_rst   (sys_rst),
    .run_tgl   (c_q.run_tgl),
    .pat_count (pattern_count),
    .lane_data (lane_data),
    .done_tgl  (done_tgl_l),
    .sticky    (sticky_l)
  );

  // Completion toggle from the link.
  bit_sync #(.W(1)) u_done_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   (done_tgl_l),
    .q   (done_s)
  );

  // Next state of the whole sequencer. The sticky word from the link side
  // is only sampled on a completion edge, when it is known to be still.
  always_comb begin
    logic         done_ev;
    logic         busy_now;
    logic         all_done;
    logic         any_err;
    logic         launch;
    done_ev  = 1'b0;
    busy_now = 1'b0;
    all_done = 1'b1;
    any_err  = 1'b0;
    launch   = 1'b0;
    c_d      = c_q;

    // Completion of a pattern run.
    done_ev     = (done_s != c_q.done_seen);
    c_d.done_seen = done_s;
    if (done_ev) begin
      c_d.busy   = 1'b0;
      c_d.sticky = sticky_l;
    end
    // A run ending now does not block.
    busy_now = c_q.busy & ~done_ev;
    any_err  = done_ev & (|sticky_l);

    // Phase-end flags: host acknowledge clears, a new set wins below.
    // A missed poll loses nothing.
    if (p1_end_ack) begin
      c_d.p1_end = 1'b0;
    end
    if (p2_end_ack) begin
      c_d.p2_end = 1'b0;
    end

    // All groups done as of this cycle.
    for (int g = 0; g < G; g++) begin
      all_done = all_done & (c_q.grp[g] == dlt_pkg::G_DONE);
    end

    // Each state waits on one event, except S_P2_END (either of two) and S_MISSION (none).
    unique case (c_q.st)
      dlt_pkg::S_IDLE: begin
        // Start is taken only from the configuration port.
        // Status and mode start clean.
        if (train_start) begin
          c_d.st        = dlt_pkg::S_LOCK;
          c_d.train_err = 1'b0;
          c_d.init_done = 1'b0;
          c_d.hs_mode   = 1'b0;
        end
      end

      dlt_pkg::S_LOCK: begin
        // Lock is checked once for the instance, not per group.
        // Groups restart at calibration.
        if (lock_s) begin
          c_d.st = dlt_pkg::S_GROUPS;
          for (int g = 0; g < G; g++) begin
            c_d.grp[g]      = dlt_pkg::G_CAL;
            c_d.grp_done[g] = 1'b0;
          end
          launch = bld_enable;
        end
      end

      dlt_pkg::S_GROUPS: begin
        // Calibration first, then repair; an optional detection run must
        // finish before repair so its sticky bits can guide it.
        for (int g = 0; g < G; g++) begin
          unique case (c_q.grp[g])
            dlt_pkg::G_CAL: begin
              if (cal_s[g] && !busy_now) begin
                c_d.grp[g] = dlt_pkg::G_LSR;
              end
            end
            dlt_pkg::G_LSR: begin
              if (lsr_s[g]) begin
                c_d.grp[g]      = dlt_pkg::G_DONE;
                c_d.grp_done[g] = 1'b1;
              end
            end
            dlt_pkg::G_DONE: begin
              // Held until the next start.
              c_d.grp[g] = dlt_pkg::G_DONE;
            end
            dlt_pkg::G_IDLE: begin
              // Not seen after lock.
              c_d.grp[g] = dlt_pkg::G_IDLE;
            end
          endcase
        end
        // Leave once every group is done.
        if (all_done) begin
          c_d.st = dlt_pkg::S_HS_WAIT;
        end
      end

      dlt_pkg::S_HS_WAIT: begin
        // High-speed mode is entered only once the host has set both ends.
        if (hs_mode_set) begin
          c_d.st      = dlt_pkg::S_P1;
          c_d.hs_mode = 1'b1;
          // Detection may join phase one.
          launch      = bld_enable;
        end
      end

      dlt_pkg::S_P1: begin
        // Phase one steps run in the analog front end; the end is flagged
        // only when they report done and any detection run finished.
        if (p1_s && !busy_now) begin
          c_d.st     = dlt_pkg::S_P1_END;
          c_d.p1_end = 1'b1;
        end
      end

      dlt_pkg::S_P1_END: begin
        // The host repairs lanes here and then starts phase two.
        // The end flag stays until acked.
        if (p2_start) begin
          c_d.st = dlt_pkg::S_P2;
          launch = 1'b1;
        end
      end

      dlt_pkg::S_P2: begin
        // Waiting for this run's compare
        // keeps the sticky word current.
        if (p2_s && !busy_now && !done_ev) begin
          c_d.st     = dlt_pkg::S_P2_END;
          c_d.p2_end = 1'b1;
          c_d.marg_valid = margin_valid;
          c_d.marginal   = margin_valid ? margin_lanes : '0;
          if (|c_q.sticky) begin
            c_d.train_err = 1'b1;
          end else begin
            c_d.init_done = 1'b1;
          end
        end
      end

      dlt_pkg::S_P2_END: begin
        // Retraining after repair reruns phase two; otherwise the host
        // releases both ends into normal operation together.
        if (p2_start) begin
          c_d.st        = dlt_pkg::S_P2;
          c_d.train_err = 1'b0;
          launch        = 1'b1;
        end else if (mission_enter && c_q.init_done && all_done) begin
          c_d.st      = dlt_pkg::S_MISSION;
          c_d.mission = 1'b1;
        end
      end

      dlt_pkg::S_MISSION: begin
        // Traffic cannot be paused; start requests are ignored and only
        // reset leaves this state.
        // Tracking runs without a pause.
        c_d.st = dlt_pkg::S_MISSION;
      end

      default: begin
        // Illegal codes go back to idle.
        c_d.st = dlt_pkg::S_IDLE;
      end
    endcase

    // Launching a run clears the captured sticky word; the link side
    // presets its generator to the seed on the toggle.
    // No launch site tests busy; each is reached only with no run in flight.
    if (launch) begin
      c_d.run_tgl = ~c_q.run_tgl;
      c_d.busy    = 1'b1;
      c_d.sticky  = '0;
    end

    // An error seen by a detection run is reported at once.
    // This set wins over a clear above.
    if (any_err) begin
      c_d.train_err = 1'b1;
    end
  end

  // One stage; reset clears every field,
  // so all outputs start low.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // Every output is a field of the registered state.
  assign seq_state              = c_q.st;
  assign group_done             = c_q.grp_done;
  assign rx_hs_mode             = c_q.hs_mode;
  assign pattern_active         = c_q.busy;
  assign p1_end                 = c_q.p1_end;
  assign p2_end                 = c_q.p2_end;
  assign marginal_valid         = c_q.marg_valid;
  assign marginal_lanes         = c_q.marginal;
  assign compare_sticky         = c_q.sticky;
  // Bit one init done, bit zero error.
  assign rx_training_status_reg = {c_q.init_done, c_q.train_err};
  assign mission_mode           = c_q.mission;
endmodule
`default_nettype wire

/* File: verification/dlt_checker_assertions.sv */
// Port checker for the link training sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
`default_nettype none
module dlt_checker (
  input wire logic                           ref_clk,
  input wire logic                           sys_rst,
  input wire logic                           pll_lock,
  input wire logic                           train_start,
  input wire logic                           p1_end_ack,
  input wire logic                           mission_enter,
  input wire logic [3:0]                     seq_state,
  input wire logic [dlt_pkg::NUM_GROUPS-1:0] group_done,
  input wire logic                           rx_hs_mode,
  input wire logic                           pattern_active,
  input wire logic                           p1_end,
  input wire logic                           p2_end,
  input wire logic [dlt_pkg::PAT_W-1:0]      compare_sticky,
  input wire logic [1:0]                     rx_training_status_reg,
  input wire logic                           mission_mode
);
  // Everything runs on the control clock and rests while in reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Sequence steps are tied to the input that causes them.
  property p_start;
    $changed(seq_state) && $past(seq_state) == dlt_pkg::S_IDLE
      |-> seq_state == dlt_pkg::S_LOCK && $past(train_start);
  endproperty
  a_start: assert property (p_start) else $error("start not caused");
  // Lock passes two synchroniser flops before the state may move on.
  property p_lock;
    $changed(seq_state) && seq_state == dlt_pkg::S_GROUPS
      |-> $past(pll_lock, 2);
  endproperty
  a_lock: assert property (p_lock) else $error("groups before lock");
  property p_hs;
    $changed(seq_state) && seq_state == dlt_pkg::S_HS_WAIT |-> &group_done;
  endproperty
  a_hs: assert property (p_hs) else $error("group not finished");
  property p_p1;
    seq_state == dlt_pkg::S_P1 |-> rx_hs_mode;
  endproperty
  a_p1: assert property (p_p1) else $error("phase one at low speed");
  property p_p1end;
    $rose(p1_end) |-> seq_state == dlt_pkg::S_P1_END;
  endproperty
  a_p1end: assert property (p_p1end) else $error("early phase end");
  property p_hold;
    $fell(p1_end) |-> $past(p1_end_ack);
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost unacked");
  property p_err;
    $rose(p2_end) |-> rx_training_status_reg[1] == !(|compare_sticky);
  endproperty
  a_err: assert property (p_err) else $error("status wrong");
  property p_mis;
    $rose(mission_mode)
      |-> seq_state == dlt_pkg::S_MISSION && $past(mission_enter);
  endproperty
  a_mis: assert property (p_mis) else $error("normal op uncaused");
  // Once traffic flows no run may start and the mode never drops.
  property p_stay;
    mission_mode |=> mission_mode && !pattern_active;
  endproperty
  a_stay: assert property (p_stay) else $error("traffic paused");

  c_mission: cover property ($rose(mission_mode));
  c_error: cover property ($rose(p2_end) && |compare_sticky);
  c_ack: cover property ($fell(p1_end));
endmodule
bind die_link_training_sequencer dlt_checker u_chk (
  .ref_clk, .sys_rst, .pll_lock, .train_start, .p1_end_ack,
  .mission_enter, .seq_state, .group_done, .rx_hs_mode, .pattern_active,
  .p1_end, .p2_end, .compare_sticky, .rx_training_status_reg, .mission_mode
);
`default_nettype wire

/* File: verification/peer_tx_model.sv */
// Peer die transmitter: sends the seeded pattern while a run is active.
// Assumes pattern_active marks runs and link_clk is the word clock.
`default_nettype none
module peer_tx_model (
  input  wire logic                      link_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      pattern_active,
  input  wire logic [dlt_pkg::PAT_W-1:0] corrupt,
  output var  logic [dlt_pkg::PAT_W-1:0] lane_data
);
  logic [2:0]                sync_q;
  logic [dlt_pkg::PAT_W-1:0] gen_q;

  // One Galois step: shift right, fold the taps in on a low one.
  function automatic logic [dlt_pkg::PAT_W-1:0] step(
    input logic [dlt_pkg::PAT_W-1:0] s);
    return (s >> 1) ^ (s[0] ? dlt_pkg::PAT_TAPS : '0);
  endfunction

  // The run flag takes one flop more than the receiver's sync, so the
  // seed stands on the lanes when the receiver takes its first word;
  // between runs the lanes keep toggling so stale words never pass.
  always @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= 3'b000;
      gen_q <= dlt_pkg::PAT_SEED;
    end else begin
      sync_q <= {sync_q[1:0], pattern_active};
      if (sync_q[1] && !sync_q[2])
        gen_q <= dlt_pkg::PAT_SEED;
      else if (sync_q[2])
        gen_q <= step(gen_q);
      else
        gen_q <= ~gen_q;
    end
  end

  // Broken lanes are imitated only where the bench asks for them.
  assign lane_data = gen_q ^ corrupt;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Top bench: drives the sequencer's pins and the peer model, notes the
// expected states in a queue and checks them as they appear.
// Assumes the package, the sequencer and the peer model compile first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, link_clk, sys_rst, pll_lock, p1_train_done, p2_train_done;
  logic train_start, bld_enable, hs_mode_set, p1_end_ack, p2_start;
  logic p2_end_ack, margin_valid, mission_enter, rx_hs_mode;
  logic pattern_active, p1_end, p2_end, marginal_valid, mission_mode;
  logic [1:0]                   drv_cal_done, ls_repair_done, group_done;
  logic [1:0]                   rx_training_status_reg;
  logic [3:0]                   seq_state, last_st;
  logic [23:0]                  pattern_count;
  logic [dlt_pkg::PAT_W-1:0]    lane_data, compare_sticky, corrupt;
  logic [dlt_pkg::LANES-1:0]    margin_lanes, marginal_lanes;
  logic [3:0]                   exp_q[$];
  int                           err_total = 0;
  int                           n_tests = 0;
  int                           cycles = 0;

  die_link_training_sequencer uut (
    .ref_clk, .sys_rst, .link_clk, .lane_data, .pll_lock, .drv_cal_done,
    .ls_repair_done, .p1_train_done, .p2_train_done, .train_start,
    .bld_enable, .hs_mode_set, .p1_end_ack, .p2_start, .p2_end_ack,
    .margin_valid, .margin_lanes, .mission_enter, .pattern_count,
    .seq_state, .group_done, .rx_hs_mode, .pattern_active, .p1_end,
    .p2_end, .marginal_valid, .marginal_lanes, .compare_sticky,
    .rx_training_status_reg, .mission_mode);
  peer_tx_model peer (.link_clk, .sys_rst, .pattern_active, .corrupt,
    .lane_data);

  // Two unrelated clocks: 50 ns control, 80 ns link.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  // Every comparison passes through here so the counts stay together.
  task automatic check(input logic [63:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // A one-cycle request launched and dropped on falling edges.
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  task automatic wait_st(input logic [3:0] st);
    for (int i = 0; i < 400 && seq_state !== st; i++)
      @(negedge ref_clk);
    check(seq_state, st, "state not reached");
  endtask

  // One whole bring-up; bld selects lane detection, err breaks lanes
  // in phase two. Group one reports repair before calibration on purpose.
  task automatic walk(input logic bld, input logic [39:0] err);
    logic [dlt_pkg::LANES-1:0] mlanes;
    mlanes = {10'($urandom), $urandom};
    pattern_count = 24'($urandom_range(15));
    bld_enable = bld;
    exp_q.push_back(dlt_pkg::S_LOCK);
    pulse(train_start);
    wait_st(dlt_pkg::S_LOCK);
    exp_q.push_back(dlt_pkg::S_GROUPS);
    pll_lock = 1'b1;
    wait_st(dlt_pkg::S_GROUPS);
    drv_cal_done = 2'b01;
    ls_repair_done = 2'b11;
    repeat (60) @(negedge ref_clk);
    check(group_done, 2'b01, "group done early");
    exp_q.push_back(dlt_pkg::S_HS_WAIT);
    drv_cal_done = 2'b11;
    wait_st(dlt_pkg::S_HS_WAIT);
    pulse(p2_start);
    exp_q.push_back(dlt_pkg::S_P1);
    pulse(hs_mode_set);
    wait_st(dlt_pkg::S_P1);
    check(rx_hs_mode, 1'b1, "high speed flag");
    exp_q.push_back(dlt_pkg::S_P1_END);
    p1_train_done = 1'b1;
    wait_st(dlt_pkg::S_P1_END);
    repeat (5) @(negedge ref_clk);
    check(p1_end, 1'b1, "phase one end lost");
    pulse(p1_end_ack);
    check(p1_end, 1'b0, "phase one end kept");
    corrupt = err;
    exp_q.push_back(dlt_pkg::S_P2);
    pulse(p2_start);
    wait_st(dlt_pkg::S_P2);
    check(pattern_active, 1'b1, "phase two run");
    margin_valid = 1'b1;
    margin_lanes = mlanes;
    exp_q.push_back(dlt_pkg::S_P2_END);
    p2_train_done = 1'b1;
    wait_st(dlt_pkg::S_P2_END);
    check(p2_end, 1'b1, "phase two end");
    check(marginal_valid, 1'b1, "margin flag");
    check(marginal_lanes, mlanes, "margin lanes");
    check(compare_sticky, err, "sticky lanes");
    check(rx_training_status_reg, {err == 0, err != 0}, "status");
    pulse(p2_end_ack);
    check(p2_end, 1'b0, "phase two end kept");
  endtask

  // Matches each new state against the oldest note in the queue.
  always @(negedge ref_clk) begin
    if (sys_rst)
      last_st = 4'h0;
    else if (seq_state !== last_st) begin
      last_st = seq_state;
      if (exp_q.size() == 0)
        check(seq_state, 4'hF, "unexpected state change");
      else
        check(seq_state, exp_q.pop_front(), "state order");
    end
  end

  // A hang is cut short far beyond the longest expected run.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_total++;
      complete_run();
    end
  end

  // Main sequence: clean bring-up to normal operation, then a reset out of
  // normal operation and a bring-up with broken lanes in phase two.
  initial begin
    {pll_lock, drv_cal_done, ls_repair_done, p1_train_done, p2_train_done,
     train_start, bld_enable, hs_mode_set, p1_end_ack, p2_start, p2_end_ack,
     margin_valid, margin_lanes, mission_enter, pattern_count, corrupt} = '0;
    sys_rst = 1'b1;
    void'($urandom(66847));
    repeat (4) @(negedge ref_clk);
    check({seq_state, group_done, p1_end, p2_end, mission_mode,
           rx_training_status_reg, compare_sticky}, '0, "reset values");
    sys_rst = 1'b0;
    walk(1'b1, '0);
    exp_q.push_back(dlt_pkg::S_MISSION);
    pulse(mission_enter);
    wait_st(dlt_pkg::S_MISSION);
    @(negedge ref_clk);
    check(mission_mode, 1'b1, "normal operation");
    pulse(train_start);
    repeat (20) @(negedge ref_clk);
    check(pattern_active, 1'b0, "retraining started");
    // Power-down order: no run sends, receive flags drop, then reset.
    {pll_lock, drv_cal_done, ls_repair_done, p1_train_done,
     p2_train_done, margin_valid} = '0;
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    walk(1'b0, {8'($urandom), $urandom} | 40'h00_0000_0001);
    // Retrain after repair: phase two again, now with clean lanes.
    corrupt = '0;
    exp_q.push_back(dlt_pkg::S_P2);
    pulse(p2_start);
    exp_q.push_back(dlt_pkg::S_P2_END);
    wait_st(dlt_pkg::S_P2_END);
    check(rx_training_status_reg, 2'b10, "retrain status");
    complete_run();
  end
endmodule
`default_nettype wire
